// >>> src/dtc_pkg.sv
package dtc_pkg;
  localparam int unsigned           ADDR_W       = 6;
  localparam int unsigned           DATA_W       = 16;
  localparam int unsigned           NUM_CH       = 16;
  // Register word addresses
  localparam logic [ADDR_W-1:0]     OFF_CH_DATA  = 6'h00;
  localparam logic [ADDR_W-1:0]     OFF_MODE_A   = 6'h10;
  localparam logic [ADDR_W-1:0]     OFF_TIMER_A  = 6'h14;
  localparam logic [ADDR_W-1:0]     OFF_TIMER_B  = 6'h15;
  localparam logic [ADDR_W-1:0]     OFF_RELOAD_A = 6'h16;
  localparam logic [ADDR_W-1:0]     OFF_RELOAD_B = 6'h17;
  localparam logic [ADDR_W-1:0]     OFF_TCTRL    = 6'h18;
  localparam logic [ADDR_W-1:0]     OFF_IRQC_A   = 6'h19;
  localparam logic [ADDR_W-1:0]     OFF_IRQC_B   = 6'h1A;
  // Timer control fields, timer A at base 0, timer B at base 8
  localparam int unsigned           TC_B_BASE    = 8;
  localparam int unsigned           TC_RUN_POS   = 0;
  localparam int unsigned           TC_MODE_POS  = 1;
  localparam int unsigned           TC_SEL_POS   = 2;
  // Interrupt control fields
  localparam int unsigned           IC_FLAG_POS  = 7;
  localparam int unsigned           IC_EN_POS    = 6;
  localparam int unsigned           IC_LVL_W     = 6;
  // Mode control fields per channel nibble
  localparam int unsigned           MC_ALLOC_POS = 3;
  // Reset values
  localparam logic [DATA_W-1:0]     RELOAD_RST   = 16'h0000;
  localparam logic [DATA_W-1:0]     TIMER_RST    = 16'h0000;
  localparam logic [DATA_W-1:0]     TIMER_MAX    = 16'hFFFF;
  // Counter-mode input select codes
  localparam logic [2:0]            SEL_GT6      = 3'h0;
  localparam logic [2:0]            SEL_RISE     = 3'h1;
  localparam logic [2:0]            SEL_FALL     = 3'h2;
  localparam logic [2:0]            SEL_ANY      = 3'h3;
  // Channel mode codes
  localparam logic [2:0]            MODE_OFF     = 3'h0;
  localparam logic [2:0]            MODE_CAP_R   = 3'h1;
  localparam logic [2:0]            MODE_CAP_F   = 3'h2;
  localparam logic [2:0]            MODE_CAP_B   = 3'h3;
  localparam logic [2:0]            MODE_CMP0    = 3'h4;
  localparam logic [2:0]            MODE_CMP1    = 3'h5;
  localparam logic [2:0]            MODE_CMP2    = 3'h6;
  localparam logic [2:0]            MODE_CMP3    = 3'h7;
  localparam int unsigned           BANK_SIZE    = 8;
endpackage : dtc_pkg

// >>> src/dtc_unit.sv
`timescale 1ns/1ps
//Contract
// - Counter mode clocks from pin or timer six
// - Timer B counts only timer-six events, code 000
// - Timer A pin edge: rising, falling or both
// - Select codes decode; 1XX reserved counts nothing
// - Timers count only while run flag set
// - Trigger at FFFF: flag irq, load reload value
// - Reload registers reset to 0000, word access
// - Overflow sets flag; enable gates interrupt output
// - Each timer has own interrupt control register
// - Sixteen 16-bit channel registers on timer A/B
// - Four mode registers: allocation bit, mode field
// - Mode 000 disables; register is plain storage
// - Modes 001/010/011 capture rising/falling/both
// - Modes 100/101 multi-event interrupt; 101 toggle output
// - Modes 110/111 one event; 111 set/reset output
// - Capture copies timer, pulses channel interrupt
// - Compare matches on exact equality only
// - Compare only cycle after hardware increment
// - Compare modes 0 and 2 leave output alone
// - Double-register compare shares one output
// - Same value fires once until next increment
// - No compare events until timer incremented
module dtc_unit (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rd_data_o,
  input  wire logic        timer_a_count_pin_i,
  input  wire logic        general_timer_six_ovf_i,
  input  wire logic [15:0] channel_pin_i,
  output logic      [15:0] channel_out_o,
  output logic      [15:0] channel_irq_line_o,
  output logic             timer_a_irq_o,
  output logic             timer_b_irq_o
);

  typedef struct packed {
    logic [1:0][15:0]  timer;
    logic [1:0][15:0]  reload;
    logic [1:0]        run;
    logic [1:0]        cmode;
    logic [1:0][2:0]   sel;
    logic [1:0]        tflag;
    logic [1:0]        tie;
    logic [1:0][5:0]   tlvl;
    logic [3:0][15:0]  mctrl;
    logic [15:0][15:0] data;
    logic [15:0]       pin_prev;
    logic              cpin_prev;
    logic [1:0]        incd;
    logic [1:0]        ovfd;
    logic [15:0]       blk;
    logic [15:0]       outv;
    logic [15:0]       chirq;
    logic [1:0]        tirq;
    logic [15:0]       rdata;
  } dtc_state_t;

  dtc_state_t q_reg;
  dtc_state_t q_next;
  logic [1:0]  trig;
  logic [1:0]  wr_tmr;
  logic [15:0] cap;
  logic [15:0] match;
  logic [15:0] tog;

  function automatic logic [2:0] ch_mode(input logic [3:0][15:0] mc, input int unsigned ch);
    logic [15:0] r;
    r = mc[ch/4];
    ch_mode = r[(ch%4)*4 +: 3];
  endfunction : ch_mode

  function automatic logic ch_alloc(input logic [3:0][15:0] mc, input int unsigned ch);
    logic [15:0] r;
    r = mc[ch/4];
    ch_alloc = r[(ch%4)*4 + dtc_pkg::MC_ALLOC_POS];
  endfunction : ch_alloc

  function automatic logic [15:0] ic_word(input logic f, input logic e, input logic [5:0] l);
    ic_word = {8'h00, f, e, l};
  endfunction : ic_word

  always_comb begin
    logic       rise_a;
    logic       fall_a;
    logic [2:0] m;
    logic [15:0] tv;
    logic       a;
    q_next = q_reg;
    rise_a = timer_a_count_pin_i && !q_reg.cpin_prev;
    fall_a = !timer_a_count_pin_i && q_reg.cpin_prev;
    m  = 3'h0;
    tv = 16'h0000;
    a  = 1'b0;
    q_next.cpin_prev = timer_a_count_pin_i;
    q_next.pin_prev  = channel_pin_i;
    q_next.chirq     = 16'h0000;
    q_next.rdata     = 16'h0000;
    wr_tmr[0] = wr_i && addr_i == dtc_pkg::OFF_TIMER_A;
    wr_tmr[1] = wr_i && addr_i == dtc_pkg::OFF_TIMER_B;
    // Count triggers
    trig[0] = 1'b0;
    if (q_reg.run[0]) begin
      if (!q_reg.cmode[0]) begin
        trig[0] = 1'b1;
      end else begin
        unique case (q_reg.sel[0])
          dtc_pkg::SEL_GT6:  trig[0] = general_timer_six_ovf_i;
          dtc_pkg::SEL_RISE: trig[0] = rise_a;
          dtc_pkg::SEL_FALL: trig[0] = fall_a;
          dtc_pkg::SEL_ANY:  trig[0] = rise_a || fall_a;
          default:           trig[0] = 1'b0;
        endcase
      end
    end
    trig[1] = 1'b0;
    if (q_reg.run[1]) begin
      if (!q_reg.cmode[1]) begin
        trig[1] = 1'b1;
      end else begin
        trig[1] = q_reg.sel[1] == dtc_pkg::SEL_GT6 && general_timer_six_ovf_i;
      end
    end
    // Timer update; a software write wins and never arms the comparator
    for (int t = 0; t < 2; t++) begin
      q_next.incd[t] = 1'b0;
      q_next.ovfd[t] = 1'b0;
      if (wr_tmr[t]) begin
        q_next.timer[t] = wr_data_i;
      end else if (trig[t]) begin
        q_next.incd[t] = 1'b1;
        if (q_reg.timer[t] == dtc_pkg::TIMER_MAX) begin
          q_next.timer[t] = q_reg.reload[t];
          q_next.ovfd[t]  = 1'b1;
        end else begin
          q_next.timer[t] = q_reg.timer[t] + 16'h0001;
        end
      end
    end
    // Register writes
    if (wr_i) begin
      unique case (addr_i)
        dtc_pkg::OFF_RELOAD_A: q_next.reload[0] = wr_data_i;
        dtc_pkg::OFF_RELOAD_B: q_next.reload[1] = wr_data_i;
        dtc_pkg::OFF_TCTRL: begin
          q_next.run[0]   = wr_data_i[dtc_pkg::TC_RUN_POS];
          q_next.cmode[0] = wr_data_i[dtc_pkg::TC_MODE_POS];
          q_next.sel[0]   = wr_data_i[dtc_pkg::TC_SEL_POS +: 3];
          q_next.run[1]   = wr_data_i[dtc_pkg::TC_B_BASE + dtc_pkg::TC_RUN_POS];
          q_next.cmode[1] = wr_data_i[dtc_pkg::TC_B_BASE + dtc_pkg::TC_MODE_POS];
          q_next.sel[1]   = wr_data_i[dtc_pkg::TC_B_BASE + dtc_pkg::TC_SEL_POS +: 3];
        end
        dtc_pkg::OFF_IRQC_A: begin
          q_next.tflag[0] = wr_data_i[dtc_pkg::IC_FLAG_POS];
          q_next.tie[0]   = wr_data_i[dtc_pkg::IC_EN_POS];
          q_next.tlvl[0]  = wr_data_i[dtc_pkg::IC_LVL_W-1:0];
        end
        dtc_pkg::OFF_IRQC_B: begin
          q_next.tflag[1] = wr_data_i[dtc_pkg::IC_FLAG_POS];
          q_next.tie[1]   = wr_data_i[dtc_pkg::IC_EN_POS];
          q_next.tlvl[1]  = wr_data_i[dtc_pkg::IC_LVL_W-1:0];
        end
        default: begin
          if (addr_i[5:4] == 2'b00) begin
            q_next.data[addr_i[3:0]] = wr_data_i;
          end else if (addr_i[5:2] == dtc_pkg::OFF_MODE_A[5:2]) begin
            q_next.mctrl[addr_i[1:0]] = wr_data_i;
          end
        end
      endcase
    end
    // Overflow flags; hardware set wins over a clearing write
    for (int t = 0; t < 2; t++) begin
      if (trig[t] && !wr_tmr[t] && q_reg.timer[t] == dtc_pkg::TIMER_MAX) begin
        q_next.tflag[t] = 1'b1;
      end
      q_next.tirq[t] = q_next.tflag[t] && q_next.tie[t];
    end
    // Channels
    cap   = 16'h0000;
    match = 16'h0000;
    tog   = 16'h0000;
    for (int c = 0; c < dtc_pkg::NUM_CH; c++) begin
      m  = ch_mode(q_reg.mctrl, c);
      a  = ch_alloc(q_reg.mctrl, c);
      tv = q_reg.timer[a];
      unique case (m)
        dtc_pkg::MODE_CAP_R: cap[c] = channel_pin_i[c] && !q_reg.pin_prev[c];
        dtc_pkg::MODE_CAP_F: cap[c] = !channel_pin_i[c] && q_reg.pin_prev[c];
        dtc_pkg::MODE_CAP_B: cap[c] = channel_pin_i[c] != q_reg.pin_prev[c];
        default:             cap[c] = 1'b0;
      endcase
      if (cap[c]) begin
        q_next.data[c]  = tv;
        q_next.chirq[c] = 1'b1;
      end
      // Comparator armed only the cycle after a hardware increment
      if (m[2] && q_reg.incd[a] && q_reg.data[c] == tv) begin
        match[c] = !(m[1] && q_reg.blk[c]);
      end
      if (q_reg.ovfd[a]) begin
        q_next.blk[c] = 1'b0;
      end
      if (match[c]) begin
        q_next.chirq[c] = 1'b1;
        if (m[1]) begin
          q_next.blk[c] = 1'b1;
        end
      end
      if (m == dtc_pkg::MODE_CMP3) begin
        if (match[c] && !q_reg.ovfd[a]) begin
          q_next.outv[c] = 1'b1;
        end else if (!match[c] && q_reg.ovfd[a]) begin
          q_next.outv[c] = 1'b0;
        end
      end
      if (m == dtc_pkg::MODE_CMP1 && match[c]) begin
        tog[c] = 1'b1;
      end
    end
    // Paired channel c+8 in mode 0 also toggles channel c in mode 1
    for (int c = 0; c < dtc_pkg::BANK_SIZE; c++) begin
      if (ch_mode(q_reg.mctrl, c) == dtc_pkg::MODE_CMP1 &&
          ch_mode(q_reg.mctrl, c + dtc_pkg::BANK_SIZE) == dtc_pkg::MODE_CMP0 &&
          match[c + dtc_pkg::BANK_SIZE]) begin
        tog[c] = !tog[c];
      end
    end
    q_next.outv = q_next.outv ^ tog;
    // Read data for the next cycle only
    if (rd_i) begin
      unique case (addr_i)
        dtc_pkg::OFF_TIMER_A:  q_next.rdata = q_reg.timer[0];
        dtc_pkg::OFF_TIMER_B:  q_next.rdata = q_reg.timer[1];
        dtc_pkg::OFF_RELOAD_A: q_next.rdata = q_reg.reload[0];
        dtc_pkg::OFF_RELOAD_B: q_next.rdata = q_reg.reload[1];
        dtc_pkg::OFF_TCTRL: begin
          q_next.rdata = {3'h0, q_reg.sel[1], q_reg.cmode[1], q_reg.run[1],
                          3'h0, q_reg.sel[0], q_reg.cmode[0], q_reg.run[0]};
        end
        dtc_pkg::OFF_IRQC_A: q_next.rdata = ic_word(q_reg.tflag[0], q_reg.tie[0], q_reg.tlvl[0]);
        dtc_pkg::OFF_IRQC_B: q_next.rdata = ic_word(q_reg.tflag[1], q_reg.tie[1], q_reg.tlvl[1]);
        default: begin
          if (addr_i[5:4] == 2'b00) begin
            q_next.rdata = q_reg.data[addr_i[3:0]];
          end else if (addr_i[5:2] == dtc_pkg::OFF_MODE_A[5:2]) begin
            q_next.rdata = q_reg.mctrl[addr_i[1:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_reg        <= '0;
      q_reg.reload <= {dtc_pkg::RELOAD_RST, dtc_pkg::RELOAD_RST};
      q_reg.timer  <= {dtc_pkg::TIMER_RST, dtc_pkg::TIMER_RST};
    end else if (ce_i) begin
      q_reg <= q_next;
    end
  end

  assign rd_data_o          = q_reg.rdata;
  assign channel_out_o      = q_reg.outv;
  assign channel_irq_line_o = q_reg.chirq;
  assign timer_a_irq_o      = q_reg.tirq[0];
  assign timer_b_irq_o      = q_reg.tirq[1];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_run_stop;
    ce_i && !q_reg.run[0] && !wr_tmr[0] |=> q_reg.timer[0] == $past(q_reg.timer[0]);
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("stopped timer moved");

  property p_ovf_reload;
    ce_i && trig[0] && !wr_tmr[0] && q_reg.timer[0] == 16'hFFFF
      |=> q_reg.timer[0] == $past(q_reg.reload[0]) && q_reg.tflag[0] && q_reg.ovfd[0];
  endproperty
  a_ovf_reload: assert property (p_ovf_reload) else $error("overflow reload wrong");

  property p_irq_gate;
    ce_i && !(wr_i && addr_i == dtc_pkg::OFF_IRQC_A) && !q_reg.tie[0] |=> !timer_a_irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked timer irq seen");

  property p_sw_no_arm;
    ce_i && wr_tmr[1] |=> !q_reg.incd[1];
  endproperty
  a_sw_no_arm: assert property (p_sw_no_arm) else $error("write armed comparator");

  property p_b_source;
    ce_i && q_reg.cmode[1] && q_reg.sel[1] != 3'h0 |-> !trig[1];
  endproperty
  a_b_source: assert property (p_b_source) else $error("timer B bad source");

  property p_reserved;
    ce_i && q_reg.cmode[0] && q_reg.sel[0][2] && !wr_tmr[0]
      |=> q_reg.timer[0] == $past(q_reg.timer[0]);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved select counted");

  property p_capture;
    ce_i && cap[5] |=> channel_irq_line_o[5]
      && q_reg.data[5] == $past(q_reg.timer[q_reg.mctrl[1][7]]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_equal;
    match[0] |-> q_reg.data[0] == q_reg.timer[q_reg.mctrl[0][3]] && $past(trig != 2'b00);
  endproperty
  a_equal: assert property (p_equal) else $error("match without equality");

  property p_quiet_out;
    ce_i && (q_reg.mctrl[0][2:0] == 3'h4 || q_reg.mctrl[0][2:0] == 3'h6)
      |=> channel_out_o[0] == $past(channel_out_o[0]);
  endproperty
  a_quiet_out: assert property (p_quiet_out) else $error("mode 0/2 moved output");

  property p_mode3_set;
    ce_i && match[0] && q_reg.mctrl[0][2:0] == 3'h7 && !q_reg.ovfd[q_reg.mctrl[0][3]]
      |=> channel_out_o[0] && q_reg.blk[0];
  endproperty
  a_mode3_set: assert property (p_mode3_set) else $error("mode 3 set failed");

endmodule : dtc_unit

// >>> dv/dtc_pins_model.sv
`timescale 1ns/1ps
module dtc_pins_model #(
  parameter int unsigned MIN_HOLD = 2
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cnt_lvl_i,
  input  wire logic        gt6_req_i,
  input  wire logic [15:0] ch_lvl_i,
  output logic             timer_a_count_pin_o,
  output logic             general_timer_six_ovf_o,
  output logic      [15:0] channel_pin_o
);
  logic [3:0] hold_reg;

  // Pin levels change only after the previous level stood MIN_HOLD+1 cycles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_reg                <= 4'h0;
      timer_a_count_pin_o     <= 1'b0;
      general_timer_six_ovf_o <= 1'b0;
      channel_pin_o           <= 16'h0000;
    end else begin
      general_timer_six_ovf_o <= gt6_req_i;
      if (hold_reg < 4'(MIN_HOLD)) begin
        hold_reg <= hold_reg + 4'h1;
      end else if ({cnt_lvl_i, ch_lvl_i} != {timer_a_count_pin_o, channel_pin_o}) begin
        timer_a_count_pin_o <= cnt_lvl_i;
        channel_pin_o       <= ch_lvl_i;
        hold_reg            <= 4'h0;
      end
    end
  end
endmodule : dtc_pins_model

// >>> dv/dtc_unit_test.sv
`timescale 1ns/1ps
module dtc_unit_test;
  localparam logic [5:0] TA = dtc_pkg::OFF_TIMER_A;
  localparam logic [5:0] TB = dtc_pkg::OFF_TIMER_B;
  localparam logic [5:0] RA = dtc_pkg::OFF_RELOAD_A;
  localparam logic [5:0] TC = dtc_pkg::OFF_TCTRL;
  localparam logic [5:0] IA = dtc_pkg::OFF_IRQC_A;
  localparam logic [5:0] CD = dtc_pkg::OFF_CH_DATA;
  localparam logic [5:0] MA = dtc_pkg::OFF_MODE_A;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic [5:0]  addr    = 6'h00;
  logic [15:0] wdat    = 16'h0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        ce      = 1'b1;
  logic        cnt_lvl = 1'b0;
  logic        gt6_req = 1'b0;
  logic [15:0] ch_lvl  = 16'h0000;
  logic [15:0] rdat, ch_out, ch_irq, ch_pin;
  logic        cpin, gt6, ta_irq, tb_irq;
  int          errors  = 0;
  int          n_tests = 0;
  int          irq_cnt [16];

  dtc_unit u_dtc_unit (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr),
    .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .timer_a_count_pin_i(cpin),
    .general_timer_six_ovf_i(gt6), .channel_pin_i(ch_pin), .channel_out_o(ch_out),
    .channel_irq_line_o(ch_irq), .timer_a_irq_o(ta_irq), .timer_b_irq_o(tb_irq));
  dtc_pins_model u_dtc_pins_model (.clk_i(clk_i), .rst_i(rst_i), .cnt_lvl_i(cnt_lvl),
    .gt6_req_i(gt6_req), .ch_lvl_i(ch_lvl), .timer_a_count_pin_o(cpin),
    .general_timer_six_ovf_o(gt6), .channel_pin_o(ch_pin));

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    for (int i = 0; i < 16; i++) irq_cnt[i] += int'(ch_irq[i]);
  end

  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task wreg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk_i);
    wr   <= 1'b0;
  endtask : wreg
  task rchk(input string n, input logic [5:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1 chk(n, rdat, e);
  endtask : rchk
  task pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      gt6_req <= 1'b1;
      @(posedge clk_i);
      gt6_req <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
  endtask : pulses
  task pins(input logic c, input logic [15:0] p);
    @(posedge clk_i);
    cnt_lvl <= c;
    ch_lvl  <= p;
    repeat (6) @(posedge clk_i);
  endtask : pins
  task setmode(input int ch, input logic [3:0] nib);
    wreg(MA + 6'(ch / 4), {12'h000, nib} << (4 * (ch % 4)));
  endtask : setmode
  task clr;
    #1;
    foreach (irq_cnt[i]) irq_cnt[i] = 0;
  endtask : clr

  task t_reset;
    rchk("reload_a", RA, 16'h0000);
    rchk("reload_b", dtc_pkg::OFF_RELOAD_B, 16'h0000);
    rchk("mode_a", MA, 16'h0000);
    wreg(MA + 6'h01, 16'hA5C3);
    rchk("mode_b", MA + 6'h01, 16'hA5C3);
    wreg(MA + 6'h01, 16'h0000);
    rchk("unmapped", 6'h3F, 16'h0000);
    clr();
    setmode(2, 4'h4);
    repeat (10) @(posedge clk_i);
    chk("cmp_before_inc", 16'(irq_cnt[2]), 16'h0000);
  endtask : t_reset
  task t_count;
    logic [15:0] ecnt [1:4] = '{16'h0001, 16'h0001, 16'h0002, 16'h0000};
    wreg(TC, 16'h0303);
    pulses(3);
    rchk("timer_a_gt6", TA, 16'h0003);
    rchk("timer_b_gt6", TB, 16'h0003);
    @(posedge clk_i);
    ce <= 1'b0;
    pulses(1);
    ce <= 1'b1;
    rchk("timer_a_frozen", TA, 16'h0003);
    wreg(TC, 16'h0302);
    pulses(2);
    rchk("timer_a_stop", TA, 16'h0003);
    rchk("timer_b_run", TB, 16'h0005);
    for (int s = 1; s <= 4; s++) begin
      wreg(TA, 16'h0000);
      wreg(TB, 16'h0000);
      wreg(TC, 16'h0303 | 16'(s << 2) | 16'(s << 10));
      pins(1'b1, 16'h0000);
      pins(1'b0, 16'h0000);
      pulses(1);
      rchk("timer_a_edges", TA, ecnt[s]);
      rchk("timer_b_pin", TB, 16'h0000);
    end
  endtask : t_count
  task t_ovf;
    wreg(TC, 16'h0303);
    wreg(RA, 16'h1234);
    wreg(TA, 16'hFFFF);
    wreg(IA, 16'h0040);
    pulses(1);
    rchk("reload", TA, 16'h1234);
    chk("irq_a_on", {15'h0000, ta_irq}, 16'h0001);
    chk("irq_b_off", {15'h0000, tb_irq}, 16'h0000);
    rchk("irqc_a", IA, 16'h00C0);
    wreg(IA, 16'h0080);
    repeat (2) @(posedge clk_i);
    chk("irq_a_masked", {15'h0000, ta_irq}, 16'h0000);
    pulses(1);
    rchk("after_reload", TA, 16'h1235);
    wreg(IA, 16'h0000);
  endtask : t_ovf
  task t_capture;
    logic [15:0] ecap [1:3] = '{16'h0001, 16'h0001, 16'h0002};
    logic        al;
    wreg(TB, 16'h0BEE);
    clr();
    for (int m = 1; m <= 3; m++) begin
      al = (m == 2);
      wreg(CD + 6'(m + 4), 16'h0000);
      setmode(m + 4, {al, 3'(m)});
      pins(1'b0, 16'(1 << (m + 4)));
      pins(1'b0, 16'h0000);
      chk("cap_irq", 16'(irq_cnt[m + 4]), ecap[m]);
      rchk("cap_data", CD + 6'(m + 4), al ? 16'h0BEE : 16'h1235);
    end
    wreg(CD + 6'h09, 16'h5A5A);
    pins(1'b0, 16'h0200);
    pins(1'b0, 16'h0000);
    rchk("plain_store", CD + 6'h09, 16'h5A5A);
    chk("plain_irq", 16'(irq_cnt[9]), 16'h0000);
  endtask : t_capture
  task t_compare;
    clr();
    wreg(CD, 16'h0005);
    wreg(CD + 6'h04, 16'h0005);
    setmode(0, 4'h4);
    setmode(4, 4'h4);
    wreg(TA, 16'h0003);
    pulses(3);
    chk("cmp0_irq", 16'(irq_cnt[0]), 16'h0001);
    chk("cmp4_irq", 16'(irq_cnt[4]), 16'h0001);
    chk("cmp0_out", ch_out, 16'h0000);
    wreg(TA, 16'h0005);
    repeat (5) @(posedge clk_i);
    chk("sw_write", 16'(irq_cnt[0]), 16'h0001);
    setmode(0, 4'h5);
    wreg(TA, 16'h0004);
    pulses(1);
    chk("toggle_on", ch_out, 16'h0001);
    wreg(TA, 16'h0004);
    pulses(1);
    chk("toggle_off", ch_out, 16'h0000);
    setmode(0, 4'h6);
    clr();
    wreg(TA, 16'h0004);
    pulses(1);
    wreg(CD, 16'h0007);
    pulses(2);
    chk("one_event", 16'(irq_cnt[0]), 16'h0001);
    setmode(0, 4'h7);
    wreg(CD, 16'h0005);
    wreg(RA, 16'h0004);
    wreg(TA, 16'hFFFF);
    pulses(2);
    chk("set_out", ch_out, 16'h0001);
    wreg(TA, 16'hFFFF);
    pulses(1);
    chk("ovf_clear", ch_out, 16'h0000);
    setmode(0, 4'h5);
    setmode(8, 4'h4);
    wreg(CD, 16'h0009);
    wreg(CD + 6'h08, 16'h0006);
    pulses(2);
    chk("double_reg", ch_out, 16'h0001);
  endtask : t_compare

  task summarize;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_count();
    t_ovf();
    t_capture();
    t_compare();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    summarize();
  end
endmodule : dtc_unit_test
